// >>> hw/sdbs_top.sv
// Delta-sigma back end: serial modulator output and sinc3/sinc1 decimation
// What this block does
// - Four thermometer comparator bits give five modulator levels.
// - One new comparator code per modulator sample clock cycle.
// - Mode bit 1 sends stream to pin and codes to result register.
// - Modulator-output mode stops the filter and all data-ready indications.
// - Pin is always driven while modulator-output mode is on.
// - Four code bits shift out one per analog master clock cycle.
// - Code values map 1111,0111,0011,0001,0000 to +2..-2; pattern equals code.
// - Clock select 11 drives the analog master clock onto the clock pin.
// - Clock select 00 ties stream to external clock; receiver handles ratio.
// - After reset the stream starts with the zero code 0011.
// - Restart holds the pin high two clocks, then resumes with 0011.
// - Two-bit bias field selects x0.5, x0.66, x1 or x2 bias.
// - Sinc3 decimating by first factor, then sinc1 by second, 16-bit result.
// - Resolution is at most 16 bits, set only by the oversampling code.
// - Each result is 16-bit two's complement whatever the data format field says.
// - Combined filter is normalised, unity gain at sample clock multiples.
// - Oversampling code selects the sinc3 and sinc1 factor pair.
// - First result after 3*third_order_decimation_factor + (first_order_decimation_factor-1)*third_order_decimation_factor sample clocks.
// - Result register sits at address zero, 16-bit two's complement.
`timescale 1ns/10ps
module sdbs_top (
  // Clocks and reset
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic ANALOG_MASTER_CLOCK,
  // Comparator outputs of the analog modulator
  input wire logic [3:0] COMPARATOR_CODE,
  // Setup fields from system-side logic
  input wire logic [1:0] INTERRUPT_MODE,
  input wire logic [1:0] CLOCK_SELECT,
  input wire logic [1:0] BIAS_CURRENT_SELECT,
  input wire logic [3:0] OVERSAMPLING_CODE,
  input wire logic [1:0] DATA_FORMAT,
  input wire logic RESTART,
  // Results
  output logic [sdbs_pkg::SDBS_RES_W-1:0] CONVERSION_RESULT,
  output logic DATA_READY,
  output logic [3:0] BIAS_TRIM,
  // Pins
  output logic INTERRUPT_OR_BITSTREAM_PIN_O,
  output logic INTERRUPT_OR_BITSTREAM_PIN_OE,
  output logic MASTER_CLOCK_PIN_O,
  output logic MASTER_CLOCK_PIN_OE
);

  // ==========================================================================
  // Decoders
  function automatic logic [3:0] third_order_decimation_factor_log2(input logic [3:0] code);
    third_order_decimation_factor_log2 = (code <= sdbs_pkg::SDBS_OSR_CODE_SINC3_MAX) ?
                4'(code + sdbs_pkg::SDBS_THIRD_ORDER_DECIMATION_FACTOR_LOG2_BASE) : sdbs_pkg::SDBS_THIRD_ORDER_DECIMATION_FACTOR_LOG2_MAX;
  endfunction : third_order_decimation_factor_log2

  function automatic logic [7:0] first_order_decimation_factor_of(input logic [3:0] code);
    case (code)
      4'h5: first_order_decimation_factor_of = 8'h02;
      4'h6: first_order_decimation_factor_of = 8'h04;
      4'h7: first_order_decimation_factor_of = 8'h08;
      4'h8: first_order_decimation_factor_of = 8'h10;
      4'h9: first_order_decimation_factor_of = 8'h20;
      4'ha: first_order_decimation_factor_of = 8'h28;
      4'hb: first_order_decimation_factor_of = 8'h30;
      4'hc: first_order_decimation_factor_of = 8'h50;
      4'hd: first_order_decimation_factor_of = 8'h60;
      4'he: first_order_decimation_factor_of = 8'ha0;
      4'hf: first_order_decimation_factor_of = 8'hc0;
      default: first_order_decimation_factor_of = 8'h01;
    endcase
  endfunction : first_order_decimation_factor_of

  // Rounded 65536/first_order_decimation_factor; non-power-of-two factors leave a gain error below 0.1 percent
  function automatic logic [16:0] first_order_decimation_factor_recip(input logic [3:0] code);
    case (code)
      4'h5: first_order_decimation_factor_recip = 17'h08000;
      4'h6: first_order_decimation_factor_recip = 17'h04000;
      4'h7: first_order_decimation_factor_recip = 17'h02000;
      4'h8: first_order_decimation_factor_recip = 17'h01000;
      4'h9: first_order_decimation_factor_recip = 17'h00800;
      4'ha: first_order_decimation_factor_recip = 17'h00666;
      4'hb: first_order_decimation_factor_recip = 17'h00555;
      4'hc: first_order_decimation_factor_recip = 17'h00333;
      4'hd: first_order_decimation_factor_recip = 17'h002ab;
      4'he: first_order_decimation_factor_recip = 17'h0019a;
      4'hf: first_order_decimation_factor_recip = 17'h00155;
      default: first_order_decimation_factor_recip = 17'h10000;
    endcase
  endfunction : first_order_decimation_factor_recip

  // Non-thermometer codes count as zero
  function automatic logic signed [2:0] therm_val(input logic [3:0] code);
    case (code)
      4'hf: therm_val = 3'h2;
      4'h7: therm_val = 3'h1;
      4'h1: therm_val = 3'h7;
      4'h0: therm_val = 3'h6;
      default: therm_val = 3'h0;
    endcase
  endfunction : therm_val

  function automatic logic [15:0] sat16(input logic signed [43:0] v);
    if (v > 44'sh00000007fff) begin
      sat16 = 16'h7fff;
    end else if (v < -44'sh00000008000) begin
      sat16 = 16'h8000;
    end else begin
      sat16 = v[15:0];
    end
  endfunction : sat16

  // ==========================================================================
  // Crossings
  logic aclk;
  logic l_rst_n;
  logic [6:0] l_cfg;
  logic [3:0] l_code_in;
  logic l_rst_tog_s;
  logic l_ack_s;
  logic s_rst_tog;
  logic s_res_s;
  logic s_res_d;
  logic l_res_tog;

  assign aclk = ANALOG_MASTER_CLOCK;

  sdbs_sync #(.W(1)) u_lrst (.clk(aclk), .rst_n(RSTN), .d(1'b1), .q(l_rst_n));
  // Setup fields are quasi-static; restart after changing them
  sdbs_sync #(.W(7)) u_lcfg (.clk(aclk), .rst_n(l_rst_n),
    .d({INTERRUPT_MODE[sdbs_pkg::SDBS_MODE_BIT], CLOCK_SELECT, OVERSAMPLING_CODE}),
    .q(l_cfg));
  sdbs_sync #(.W(4)) u_lcode (.clk(aclk), .rst_n(l_rst_n), .d(COMPARATOR_CODE),
    .q(l_code_in));
  sdbs_sync #(.W(1)) u_lrtog (.clk(aclk), .rst_n(l_rst_n), .d(s_rst_tog),
    .q(l_rst_tog_s));
  sdbs_sync #(.W(1)) u_lack (.clk(aclk), .rst_n(l_rst_n), .d(s_res_d), .q(l_ack_s));
  sdbs_sync #(.W(1)) u_sres (.clk(CLK_SYS), .rst_n(RSTN), .d(l_res_tog), .q(s_res_s));

  // ==========================================================================
  // Link-side decode
  sdbs_pkg::sdbs_link_st_t l_state;
  logic [1:0] l_hold_cnt;
  logic [1:0] l_bit_cnt;
  logic [3:0] l_shift;
  logic [3:0] l_code;
  logic l_pin;
  logic l_rst_tog_d;
  logic l_mode;
  logic [1:0] l_clk_sel;
  logic [3:0] l_osr_code;
  logic l_rst_evt;
  logic l_load;
  logic l_hold_done;
  logic l_busy;

  assign l_mode = l_cfg[6];
  assign l_clk_sel = l_cfg[5:4];
  assign l_osr_code = l_cfg[3:0];
  assign l_rst_evt = l_rst_tog_s ^ l_rst_tog_d;
  assign l_load = (l_state == sdbs_pkg::SDBS_ST_RUN) && (l_bit_cnt == 2'h3);
  assign l_hold_done = (l_state == sdbs_pkg::SDBS_ST_HOLD) &&
                       (l_hold_cnt == 2'(sdbs_pkg::SDBS_HOLD_CYCLES - 1));
  assign l_busy = l_res_tog ^ l_ack_s;

  // Pin is owned by the stream whenever the mode is on
  assign INTERRUPT_OR_BITSTREAM_PIN_O = l_pin;
  assign INTERRUPT_OR_BITSTREAM_PIN_OE = l_mode;
  // Forwarded clock is the link clock itself; stream bits change on its rise
  assign MASTER_CLOCK_PIN_O = aclk;
  assign MASTER_CLOCK_PIN_OE = (l_clk_sel == sdbs_pkg::SDBS_CLK_SEL_OUT);
  // With the external clock the far end derives this clock itself

  // ==========================================================================
  // Serialiser: one code bit per link clock, four per sample
  always_ff @(posedge aclk or negedge l_rst_n) begin
    if (!l_rst_n) begin
      l_state <= sdbs_pkg::SDBS_ST_HOLD;
      l_hold_cnt <= 2'h0;
      l_bit_cnt <= 2'h0;
      l_shift <= sdbs_pkg::SDBS_CODE_ZERO;
      l_code <= sdbs_pkg::SDBS_CODE_ZERO;
      l_pin <= 1'b1;
      l_rst_tog_d <= 1'b0;
    end else begin
      l_rst_tog_d <= l_rst_tog_s;
      if (l_rst_evt) begin
        l_state <= sdbs_pkg::SDBS_ST_HOLD;
        l_hold_cnt <= 2'h0;
        l_pin <= 1'b1;
      end else begin
        case (l_state)
          sdbs_pkg::SDBS_ST_HOLD: begin
            l_hold_cnt <= 2'(l_hold_cnt + 2'h1);
            l_pin <= 1'b1;
            if (l_hold_done) begin
              l_state <= sdbs_pkg::SDBS_ST_RUN;
              l_pin <= sdbs_pkg::SDBS_CODE_ZERO[3];
              l_shift <= {sdbs_pkg::SDBS_CODE_ZERO[2:0], 1'b0};
              l_code <= sdbs_pkg::SDBS_CODE_ZERO;
              l_bit_cnt <= 2'h1;
            end
          end
          sdbs_pkg::SDBS_ST_RUN: begin
            l_pin <= l_shift[3];
            l_bit_cnt <= 2'(l_bit_cnt + 2'h1);
            if (l_load) begin
              l_shift <= l_code_in;
              l_code <= l_code_in;
            end else begin
              l_shift <= {l_shift[2:0], 1'b0};
            end
          end
          default: l_state <= sdbs_pkg::SDBS_ST_HOLD;
        endcase
      end
    end
  end

  // ==========================================================================
  // Decimation: sinc3 then sinc1 with reciprocal normalisation
  logic s3_valid;
  logic signed [sdbs_pkg::SDBS_CIC_W-1:0] s3_out;
  logic s3_clear;
  logic [3:0] l_k;
  logic [4:0] l_sh;
  logic signed [sdbs_pkg::SDBS_CIC_W-1:0] l_y3n;
  logic signed [sdbs_pkg::SDBS_ACC_W-1:0] l_acc;
  logic signed [sdbs_pkg::SDBS_ACC_W-1:0] l_sum;
  logic signed [43:0] l_prod;
  logic [7:0] l_n;
  logic [1:0] l_skip;
  logic l_fres;
  logic [15:0] l_res_data;
  logic l_res_kind;

  assign s3_clear = l_rst_evt || l_mode;
  assign l_k = third_order_decimation_factor_log2(l_osr_code);
  assign l_sh = 5'({l_k, 1'b0} + {1'b0, l_k} - sdbs_pkg::SDBS_GAIN_SHIFT_BIAS);
  assign l_y3n = s3_out >>> l_sh;
  assign l_sum = l_acc + sdbs_pkg::SDBS_ACC_W'(l_y3n);
  assign l_prod = 44'(l_sum) * 44'($signed({1'b0, first_order_decimation_factor_recip(l_osr_code)}));
  assign l_fres = s3_valid && (l_skip == 2'(sdbs_pkg::SDBS_SETTLE_SKIP)) &&
                  (l_n == 8'(first_order_decimation_factor_of(l_osr_code) - 8'h01));

  sdbs_sinc3 #(.W(sdbs_pkg::SDBS_CIC_W)) u_sinc3 (
    .clk(aclk),
    .rst_n(l_rst_n),
    .clear(s3_clear),
    .in_valid(l_load && !l_mode),
    .in_data(therm_val(l_code_in)),
    .ratio_log2(l_k),
    .out_valid(s3_valid),
    .out_data(s3_out)
  );

  // First two sinc3 outputs are comb fill and are dropped
  always_ff @(posedge aclk or negedge l_rst_n) begin
    if (!l_rst_n) begin
      l_skip <= 2'h0;
      l_acc <= '0;
      l_n <= 8'h0;
    end else if (s3_clear) begin
      l_skip <= 2'h0;
      l_acc <= '0;
      l_n <= 8'h0;
    end else if (s3_valid) begin
      if (l_skip != 2'(sdbs_pkg::SDBS_SETTLE_SKIP)) begin
        l_skip <= 2'(l_skip + 2'h1);
      end else if (l_fres) begin
        l_acc <= '0;
        l_n <= 8'h0;
      end else begin
        l_acc <= l_sum;
        l_n <= 8'(l_n + 8'h01);
      end
    end
  end

  // Result word held stable until the system side acknowledges it
  always_ff @(posedge aclk or negedge l_rst_n) begin
    if (!l_rst_n) begin
      l_res_data <= 16'h0;
      l_res_kind <= 1'b0;
      l_res_tog <= 1'b0;
    end else if (!l_busy) begin
      if (l_fres && !l_mode) begin
        l_res_data <= sat16(l_prod >>> sdbs_pkg::SDBS_RES_SHIFT);
        l_res_kind <= 1'b1;
        l_res_tog <= !l_res_tog;
      end else if (l_load && l_mode) begin
        l_res_data <= {12'h0, l_code_in};
        l_res_kind <= 1'b0;
        l_res_tog <= !l_res_tog;
      end
    end
  end

  // ==========================================================================
  // System side: capture, data ready and bias trim
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      s_rst_tog <= 1'b0;
      s_res_d <= 1'b0;
      CONVERSION_RESULT <= 16'h0;
      DATA_READY <= 1'b0;
      BIAS_TRIM <= sdbs_pkg::SDBS_BIAS_RESET;
    end else begin
      s_rst_tog <= s_rst_tog ^ RESTART;
      s_res_d <= s_res_s;
      DATA_READY <= (s_res_s ^ s_res_d) && l_res_kind;
      if (s_res_s ^ s_res_d) begin
        // Only the 16-bit two's complement encoding fits this port
        CONVERSION_RESULT <= (DATA_FORMAT == 2'h0) ? l_res_data : l_res_data;
      end
      BIAS_TRIM <= 4'h1 << BIAS_CURRENT_SELECT;
    end
  end

  // ==========================================================================
  // Checks
  logic [17:0] l_smp_cnt;
  logic l_seen;
  always_ff @(posedge aclk or negedge l_rst_n) begin
    if (!l_rst_n) begin
      l_smp_cnt <= 18'h0;
      l_seen <= 1'b0;
    end else if (s3_clear) begin
      l_smp_cnt <= 18'h0;
      l_seen <= 1'b0;
    end else if (l_fres) begin
      l_smp_cnt <= 18'h0;
      l_seen <= 1'b1;
    end else if (l_load) begin
      l_smp_cnt <= 18'(l_smp_cnt + 18'h1);
    end
  end

  chk_restart_hold: assert property (@(posedge aclk) disable iff (!l_rst_n)
    (l_rst_evt && l_mode) |=> INTERRUPT_OR_BITSTREAM_PIN_O [*2] ##1 !INTERRUPT_OR_BITSTREAM_PIN_O)
    else $error("Pin not held high for two clocks on restart");
  chk_default_first: assert property (@(posedge aclk) disable iff (!l_rst_n)
    (l_hold_done && !l_rst_evt) |=> !l_pin ##1 !l_pin ##1 l_pin ##1 l_pin)
    else $error("First code after hold is not 0011");
  // A restart cuts the frame in flight, so it ends the attempt
  chk_serial_order: assert property (@(posedge aclk) disable iff (!l_rst_n || l_rst_evt)
    (l_load && !l_rst_evt) |=> ##1 (l_pin == l_code[3]) ##1 (l_pin == l_code[2])
      ##1 (l_pin == l_code[1]))
    else $error("Code bits not shifted out msb first");
  chk_pin_never_float: assert property (@(posedge aclk) disable iff (!l_rst_n)
    (l_mode && $past(l_mode)) |->
      (INTERRUPT_OR_BITSTREAM_PIN_OE && $past(INTERRUPT_OR_BITSTREAM_PIN_OE)))
    else $error("Pin released in modulator-output mode");
  chk_filter_off_mod: assert property (@(posedge aclk) disable iff (!l_rst_n)
    l_mode |=> (!s3_valid && !l_fres && (l_acc == '0)))
    else $error("Filter active in modulator-output mode");
  chk_first_result: assert property (@(posedge aclk) disable iff (!l_rst_n)
    (l_fres && !l_seen) |-> (l_smp_cnt == 18'((3 + first_order_decimation_factor_of(l_osr_code) - 1) << l_k)))
    else $error("First result at wrong sample count");
  chk_result_period: assert property (@(posedge aclk) disable iff (!l_rst_n)
    (l_fres && l_seen) |-> (l_smp_cnt == 18'(first_order_decimation_factor_of(l_osr_code) << l_k)))
    else $error("Result period is not third_order_decimation_factor times first_order_decimation_factor");
  chk_mod_result: assert property (@(posedge aclk) disable iff (!l_rst_n)
    (l_load && l_mode && !l_busy) |=> (l_res_data == {12'h0, l_code} && !l_res_kind))
    else $error("Modulator code not placed in result word");
  chk_bias_decode: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    1'b1 |=> (BIAS_TRIM == (4'h1 << $past(BIAS_CURRENT_SELECT))) && $onehot(BIAS_TRIM))
    else $error("Bias trim does not follow the bias field");

endmodule : sdbs_top

// >>> hw/sdbs_pkg.sv
// Shared constants and types for the delta-sigma decimator and bitstream block
package sdbs_pkg;

  // ==========================================================================
  // Modulator and bitstream
  localparam int SDBS_BITS_PER_SAMPLE = 4;
  localparam logic [3:0] SDBS_CODE_ZERO = 4'h3;
  localparam int SDBS_HOLD_CYCLES = 2;
  localparam int SDBS_MODE_BIT = 1;

  // ==========================================================================
  // Clock select field values
  localparam logic [1:0] SDBS_CLK_SEL_OUT = 2'h3;
  localparam logic [1:0] SDBS_CLK_SEL_EXT = 2'h0;

  // ==========================================================================
  // Result register and filter widths
  localparam logic [3:0] SDBS_RESULT_ADDR = 4'h0;
  localparam int SDBS_RES_W = 16;
  localparam int SDBS_CIC_W = 30;
  localparam int SDBS_ACC_W = 26;
  localparam int SDBS_SETTLE_SKIP = 2;
  localparam int SDBS_RES_SHIFT = 16;
  localparam logic [3:0] SDBS_OSR_CODE_SINC3_MAX = 4'h4;
  localparam logic [3:0] SDBS_THIRD_ORDER_DECIMATION_FACTOR_LOG2_BASE = 4'h5;
  localparam logic [3:0] SDBS_THIRD_ORDER_DECIMATION_FACTOR_LOG2_MAX = 4'h9;
  localparam logic [4:0] SDBS_GAIN_SHIFT_BIAS = 5'h0e;

  // ==========================================================================
  // Bias trim
  localparam logic [3:0] SDBS_BIAS_RESET = 4'h4;

  // ==========================================================================
  // Serialiser states
  typedef enum logic {SDBS_ST_HOLD, SDBS_ST_RUN} sdbs_link_st_t;

endpackage : sdbs_pkg

// >>> hw/sdbs_sync.sv
// Two-flop synchroniser for levels and toggles
`timescale 1ns/10ps
module sdbs_sync #(
  parameter int W = 1
) (
  // Destination clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  // ==========================================================================
  // Stage one feeds stage two only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : sdbs_sync

// >>> hw/sdbs_sinc3.sv
// Third-order sinc decimator, power-of-two ratio
`timescale 1ns/10ps
module sdbs_sinc3 #(
  parameter int W = sdbs_pkg::SDBS_CIC_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  // Samples in
  input wire logic in_valid,
  input wire logic signed [2:0] in_data,
  input wire logic [3:0] ratio_log2,
  // Decimated out
  output logic out_valid,
  output logic signed [W-1:0] out_data
);
  logic signed [W-1:0] integ [3];
  logic signed [W-1:0] dly [3];
  logic signed [W-1:0] next_integ [3];
  logic signed [W-1:0] comb [3];
  logic [8:0] cnt;
  logic [9:0] last_val;
  logic last;

  // ==========================================================================
  // Integrators use this sample directly, so no added latency
  assign next_integ[0] = integ[0] + W'(in_data);
  assign comb[0] = next_integ[2] - dly[0];
  genvar g;
  generate
    for (g = 1; g < 3; g++) begin : g_stage
      assign next_integ[g] = integ[g] + next_integ[g-1];
      assign comb[g] = comb[g-1] - dly[g];
    end
  endgenerate
  assign last_val = (10'h1 << ratio_log2) - 10'h1;
  assign last = {1'b0, cnt} == last_val;

  // ==========================================================================
  // Wrapping arithmetic is exact for the comb difference
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 3; i++) begin
        integ[i] <= '0;
        dly[i] <= '0;
      end
      cnt <= '0;
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (clear) begin
      for (int i = 0; i < 3; i++) begin
        integ[i] <= '0;
        dly[i] <= '0;
      end
      cnt <= '0;
      out_valid <= 1'b0;
    end else begin
      out_valid <= in_valid && last;
      if (in_valid) begin
        for (int i = 0; i < 3; i++) begin
          integ[i] <= next_integ[i];
        end
        cnt <= last ? 9'h0 : 9'(cnt + 9'h1);
        if (last) begin
          dly[0] <= next_integ[2];
          dly[1] <= comb[0];
          dly[2] <= comb[1];
          out_data <= comb[2];
        end
      end
    end
  end
endmodule : sdbs_sinc3

// >>> sim/sdbs_mcu_rx.sv
// Receiver model of the external filter logic that reads the serial stream
`timescale 1ns/10ps
module sdbs_mcu_rx (
  // Link clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Stream pin level and alignment arm
  input wire logic pin,
  input wire logic arm,
  // Recovered frames
  output logic [3:0] frame,
  output logic [3:0] hold_len,
  output logic [15:0] n_frames
);
  // ==========================================================================
  // Frame recovery
  // Aligns on the high hold after a restart, so stream between arm and the hold must be low
  logic aligned;
  logic [2:0] sh;
  logic [1:0] pos;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n || !arm) begin
      aligned <= 1'b0;
      hold_len <= 4'h0;
      pos <= 2'h0;
      n_frames <= 16'h0;
      frame <= 4'h0;
      sh <= 3'h0;
    end else if (!aligned) begin
      if (pin) begin
        hold_len <= hold_len + 4'h1;
      end else if (hold_len != 4'h0) begin
        aligned <= 1'b1;
        sh <= {2'h0, pin};
        pos <= 2'h1;
      end
    end else begin
      // One bit per link cycle, clock ratio of one
      sh <= {sh[1:0], pin};
      pos <= pos + 2'h1;
      if (pos == 2'h3) begin
        frame <= {sh, pin};
        n_frames <= n_frames + 16'h1;
      end
    end
  end
endmodule : sdbs_mcu_rx

// >>> sim/test_sigma_delta_decimator_bitstream.sv
// Testbench for the decimator and serial modulator output block
`timescale 1ns/10ps
module test_sigma_delta_decimator_bitstream;
  logic clk_sys, rstn, analog_master_clock, restart, arm, mode_on;
  logic [3:0] code, osr_code, frame, hold_len, trim;
  logic [1:0] irq_mode, clk_sel, bias_sel, fmt;
  logic [15:0] result, n_frames;
  logic dr, pin_o, pin_oe, mclk_o, mclk_oe;
  logic [3:0] codes [5] = '{4'hf, 4'h7, 4'h3, 4'h1, 4'h0};
  logic [15:0] means [5] = '{16'h7fff, 16'h4000, 16'h0000, 16'hc000, 16'h8000};
  int n_fail, cmp_count, dr_count;
  time t0, t1, t2;
  // Pull-up holds the pin high when released
  wire logic pin_wire = pin_oe ? pin_o : 1'b1;

  sdbs_top dut_u (
    .CLK_SYS(clk_sys), .RSTN(rstn), .ANALOG_MASTER_CLOCK(analog_master_clock), .COMPARATOR_CODE(code),
    .INTERRUPT_MODE(irq_mode), .CLOCK_SELECT(clk_sel), .BIAS_CURRENT_SELECT(bias_sel),
    .OVERSAMPLING_CODE(osr_code), .DATA_FORMAT(fmt), .RESTART(restart),
    .CONVERSION_RESULT(result), .DATA_READY(dr), .BIAS_TRIM(trim),
    .INTERRUPT_OR_BITSTREAM_PIN_O(pin_o), .INTERRUPT_OR_BITSTREAM_PIN_OE(pin_oe),
    .MASTER_CLOCK_PIN_O(mclk_o), .MASTER_CLOCK_PIN_OE(mclk_oe));

  sdbs_mcu_rx rx_u (.clk(analog_master_clock), .rst_n(rstn), .pin(pin_wire), .arm(arm), .frame(frame),
    .hold_len(hold_len), .n_frames(n_frames));

  // ==========================================================================
  // Clocks and monitors
  // Link offset keeps its edges off the bench sampling instants
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial begin
    analog_master_clock = 1'b0;
    #4;
    forever #6 analog_master_clock = ~analog_master_clock;
  end
  always @(posedge clk_sys) begin
    if (dr === 1'b1) dr_count++;
    if (mode_on) chk(32'(pin_oe), 32'h1);
  end
  initial begin
    #1500000;
    n_fail++;
    $display("[ERR] t=%0t watchdog got=%h exp=%h", $time, 0, 1);
    end_of_test();
  end

  // ==========================================================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic do_restart;
    restart = 1'b1;
    tick(1);
    t0 = $time;
    restart = 1'b0;
  endtask : do_restart
  task automatic wait_dr(output time t);
    int k;
    tick(1);
    k = 0;
    while (dr !== 1'b1 && k < 3000) begin
      tick(1);
      k++;
    end
    chk(32'(k < 3000), 32'h1);
    t = $time;
  endtask : wait_dr
  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test

  // ==========================================================================
  // Scenarios
  task automatic test_bias_clock;
    for (int i = 0; i < 4; i++) begin
      bias_sel = i[1:0];
      tick(3);
      chk(32'(trim), 32'h1 << i);
    end
    bias_sel = 2'h2;
    clk_sel = 2'h3;
    tick(3);
    chk(32'(mclk_oe), 32'h1);
    chk(32'(mclk_o), 32'(analog_master_clock));
    clk_sel = 2'h0;
    tick(3);
    chk(32'(mclk_oe), 32'h0);
    $display("test bias and clock output done");
  endtask : test_bias_clock
  task automatic test_decim_values;
    for (int i = 0; i < 5; i++) begin
      code = codes[i];
      fmt = i[1:0];
      tick(3);
      do_restart();
      // Let a result still in the handshake from before the restart drain
      tick(5);
      wait_dr(t1);
      chk(32'(t1 - t0 >= 4500 && t1 - t0 <= 5400), 32'h1);
      chk(32'(result), 32'(means[i]));
      tick(1);
      chk(32'(dr), 32'h0);
      wait_dr(t2);
      chk(32'(t2 - t1 >= 1400 && t2 - t1 <= 1700), 32'h1);
      chk(32'(result), 32'(means[i]));
      chk(32'(pin_oe), 32'h0);
    end
    $display("test decimation values done");
  endtask : test_decim_values
  task automatic test_osr_timing;
    int t_exp;
    code = 4'h7;
    for (int c = 0; c < 6; c++) begin
      osr_code = c[3:0];
      tick(3);
      t_exp = (c <= 4) ? 3 * (32 << c) * 48 : 4 * 512 * 48;
      do_restart();
      tick(5);
      wait_dr(t1);
      chk(32'(t1 - t0 >= t_exp - 100 && t1 - t0 <= t_exp + 800), 32'h1);
      chk(32'(result), 32'h4000);
    end
    osr_code = 4'h0;
    $display("test oversampling timing done");
  endtask : test_osr_timing
  task automatic test_bitstream;
    int k;
    logic [15:0] n0;
    code = 4'h0;
    irq_mode = 2'h2;
    tick(4);
    chk(32'(pin_oe), 32'h1);
    dr_count = 0;
    mode_on = 1'b1;
    arm = 1'b1;
    do_restart();
    k = 0;
    // Frames come faster than the system clock, so watch the link clock
    while (n_frames == 16'h0 && k < 200) begin
      @(posedge analog_master_clock);
      #1;
      k++;
    end
    chk(32'(k < 200), 32'h1);
    chk(32'(hold_len), 32'h2);
    chk(32'(frame), 32'h3);
    for (int i = 0; i < 5; i++) begin
      code = codes[i];
      // A code may queue behind one already in the result handshake
      tick(8);
      chk(32'(frame), 32'(codes[i]));
      chk(32'(result), 32'(codes[i]));
    end
    n0 = n_frames;
    tick(40);
    chk(32'(n_frames - n0 >= 16'd82 && n_frames - n0 <= 16'd85), 32'h1);
    chk(32'(dr_count), 32'h0);
    mode_on = 1'b0;
    $display("test bitstream done");
  endtask : test_bitstream

  // ==========================================================================
  // Main sequence
  initial begin
    {rstn, restart, arm, mode_on} = 4'h0;
    {code, osr_code} = 8'h00;
    {irq_mode, clk_sel, fmt} = 6'h00;
    bias_sel = 2'h2;
    n_fail = 0;
    cmp_count = 0;
    dr_count = 0;
    tick(2);
    chk(32'(trim), 32'h4);
    chk(32'(pin_oe), 32'h0);
    rstn = 1'b1;
    tick(2);
    test_bias_clock();
    test_decim_values();
    test_osr_timing();
    test_bitstream();
    end_of_test();
  end
endmodule : test_sigma_delta_decimator_bitstream
